// ==== src/dfsc_pkg.sv ====
package dfsc_pkg;

   // register field positions
   localparam int unsigned EXT_QUAL_BIT    = 12;
   localparam int unsigned WNR_BIT         = 11;
   localparam int unsigned FS_UPPER_BIT    = 10;
   localparam int unsigned DOMAIN_LSB      = 4;
   localparam int unsigned STATUS_LSB      = 0;

   // register selector: primary register 5, secondary 0, opcode2 0
   localparam logic [3:0]  CRN_SEL         = 4'h5;
   localparam logic [3:0]  CRM_SEL         = 4'h0;
   localparam logic [2:0]  OPC2_SEL        = 3'h0;

   // value after reset
   localparam logic [31:0] DFS_RESET       = 32'h0000_0000;

   // writable bits: 12, 11, 10, 7..0
   localparam logic [31:0] DFS_WMASK       = 32'h0000_1CFF;

   // fault cause priority index, highest first
   typedef enum logic [3:0] {
      DFSC_ALIGN     = 4'h0,
      DFSC_ICMAINT   = 4'h1,
      DFSC_EXT_L1    = 4'h2,
      DFSC_EXT_L2    = 4'h3,
      DFSC_TRANS_SEC = 4'h4,
      DFSC_TRANS_PG  = 4'h5,
      DFSC_AF_SEC    = 4'h6,
      DFSC_AF_PG     = 4'h7,
      DFSC_DOM_SEC   = 4'h8,
      DFSC_DOM_PG    = 4'h9,
      DFSC_PERM_SEC  = 4'hA,
      DFSC_PERM_PG   = 4'hB,
      DFSC_EXT_SYNC  = 4'hC,
      DFSC_EXT_ASYNC = 4'hD,
      DFSC_DEBUG     = 4'hE
   } dfsc_cause_e;

   localparam int unsigned NUM_CAUSES      = 15;

   // five-bit status codes (fs[4], fs[3:0])
   localparam logic [4:0] FS_ALIGN     = 5'h01;
   localparam logic [4:0] FS_ICMAINT   = 5'h04;
   localparam logic [4:0] FS_EXT_L1    = 5'h0C;
   localparam logic [4:0] FS_EXT_L2    = 5'h0E;
   localparam logic [4:0] FS_TRANS_SEC = 5'h05;
   localparam logic [4:0] FS_TRANS_PG  = 5'h07;
   localparam logic [4:0] FS_AF_SEC    = 5'h03;
   localparam logic [4:0] FS_AF_PG     = 5'h06;
   localparam logic [4:0] FS_DOM_SEC   = 5'h09;
   localparam logic [4:0] FS_DOM_PG    = 5'h0B;
   localparam logic [4:0] FS_PERM_SEC  = 5'h0D;
   localparam logic [4:0] FS_PERM_PG   = 5'h0F;
   localparam logic [4:0] FS_EXT_SYNC  = 5'h08;
   localparam logic [4:0] FS_EXT_ASYNC = 5'h16;
   localparam logic [4:0] FS_DEBUG     = 5'h02;

endpackage

// ==== src/dfsc_capture.sv ====
// Function
// RULE1: on a data abort record cause, domain and access type
// RULE2: reachable only when privileged; separate copies for secure and non-secure
// RULE3: bit 12 qualifies external aborts, 0 decode, 1 slave; else zero
// RULE4: bit 11 holds access direction, 0 read, 1 write
// RULE5: aborted system control coprocessor operation sets write bit to 1
// RULE6: bit 10 holds status bit 4
// RULE7: bits 9 and 8 always read zero
// RULE8: bits 7 to 4 hold the accessed domain, one of 16
// RULE9: fault type from bits 3..0 with 12 and 10, fixed priority
// RULE10: alignment 000001 highest, icache maintenance 000100 next
// RULE11: walk external abort x01100 first level, x01110 second level
// RULE12: translation fault 000101 section, 000111 page
// RULE13: access flag fault 000011 section, 000110 page
// RULE14: domain fault 001001 section, 001011 page
// RULE15: permission fault 001101 section, 001111 page
// RULE16: sync external nontranslation x01000, async external x10110, below permission
// RULE17: debug event 00010, lowest priority
// RULE18: unlisted encodings are reserved and never produced
// RULE19: bus error qualifier resets to 0 (decode error)
// RULE20: coprocessor read with opcode2 0 returns register contents
// RULE21: coprocessor write loads register with written data
// RULE22: software updates register only by read-modify-write
// RULE23: contents held until next abort or software write
module dfsc_capture
   import dfsc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   // abort report from the load/store path
   input  wire logic        abort_valid_in,
   input  wire logic [14:0] abort_cause_in,
   input  wire logic [3:0]  abort_domain_in,
   input  wire logic        abort_write_in,
   input  wire logic        abort_cp_op_in,
   input  wire logic        abort_slverr_in,
   input  wire logic        abort_nonsecure_in,
   // system control coprocessor access
   input  wire logic        cp_rd_in,
   input  wire logic        cp_wr_in,
   input  wire logic [3:0]  cp_crn_in,
   input  wire logic [3:0]  cp_crm_in,
   input  wire logic [2:0]  cp_opc2_in,
   input  wire logic [31:0] cp_wdata_in,
   input  wire logic        cp_privileged_in,
   input  wire logic        cp_nonsecure_in,
   output logic      [31:0] cp_rdata_out,
   output logic             cp_rvalid_out,
   output logic             cp_undef_out
);

   logic [31:0] dfs_s_q;
   logic [31:0] dfs_s_d;
   logic [31:0] dfs_ns_q;
   logic [31:0] dfs_ns_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;
   logic        undef_q;
   logic        undef_d;

   logic        sel_hit;
   logic        any_cause;
   logic        is_ext;
   logic [4:0]  fs_code;
   logic [31:0] capture_val;
   dfsc_cause_e win;

   // pick the highest-priority cause present; lower index ranks higher
   always_comb begin
      win       = DFSC_DEBUG;
      any_cause = 1'b0;
      for (int i = NUM_CAUSES - 1; i >= 0; i--) begin // RULE9
         if (abort_cause_in[i]) begin
            win       = dfsc_cause_e'(i[3:0]);
            any_cause = 1'b1;
         end
      end
   end

   // cause to five-bit status code; only listed codes can appear
   always_comb begin
      is_ext = 1'b0;
      case (win) // RULE18
         DFSC_ALIGN: begin
            fs_code = FS_ALIGN; // RULE10
         end
         DFSC_ICMAINT: begin
            fs_code = FS_ICMAINT; // RULE10
         end
         DFSC_EXT_L1: begin
            fs_code = FS_EXT_L1; // RULE11
            is_ext  = 1'b1;
         end
         DFSC_EXT_L2: begin
            fs_code = FS_EXT_L2; // RULE11
            is_ext  = 1'b1;
         end
         DFSC_TRANS_SEC: begin
            fs_code = FS_TRANS_SEC; // RULE12
         end
         DFSC_TRANS_PG: begin
            fs_code = FS_TRANS_PG; // RULE12
         end
         DFSC_AF_SEC: begin
            fs_code = FS_AF_SEC; // RULE13
         end
         DFSC_AF_PG: begin
            fs_code = FS_AF_PG; // RULE13
         end
         DFSC_DOM_SEC: begin
            fs_code = FS_DOM_SEC; // RULE14
         end
         DFSC_DOM_PG: begin
            fs_code = FS_DOM_PG; // RULE14
         end
         DFSC_PERM_SEC: begin
            fs_code = FS_PERM_SEC; // RULE15
         end
         DFSC_PERM_PG: begin
            fs_code = FS_PERM_PG; // RULE15
         end
         DFSC_EXT_SYNC: begin
            fs_code = FS_EXT_SYNC; // RULE16
            is_ext  = 1'b1;
         end
         DFSC_EXT_ASYNC: begin
            fs_code = FS_EXT_ASYNC; // RULE16
            is_ext  = 1'b1;
         end
         default: begin
            fs_code = FS_DEBUG; // RULE17
         end
      endcase
   end

   // assemble the captured word
   always_comb begin
      capture_val                       = 32'h0000_0000;
      capture_val[EXT_QUAL_BIT]         = is_ext & abort_slverr_in; // RULE3
      capture_val[WNR_BIT]              = abort_write_in | abort_cp_op_in; // RULE4 RULE5
      capture_val[FS_UPPER_BIT]         = fs_code[4]; // RULE6
      capture_val[DOMAIN_LSB +: 4]      = abort_domain_in; // RULE8
      capture_val[STATUS_LSB +: 4]      = fs_code[3:0]; // RULE9
   end

   assign sel_hit = (cp_crn_in == CRN_SEL) && (cp_crm_in == CRM_SEL)
                    && (cp_opc2_in == OPC2_SEL);

   // banked register update: abort capture wins over a same-cycle write
   always_comb begin
      dfs_s_d  = dfs_s_q; // RULE23
      dfs_ns_d = dfs_ns_q;
      if (cp_wr_in && sel_hit && cp_privileged_in) begin // RULE2
         if (cp_nonsecure_in) begin
            dfs_ns_d = cp_wdata_in & DFS_WMASK; // RULE21 RULE7
         end else begin
            dfs_s_d = cp_wdata_in & DFS_WMASK; // RULE21 RULE7
         end
      end
      if (abort_valid_in && any_cause) begin // RULE1
         if (abort_nonsecure_in) begin
            dfs_ns_d = capture_val;
         end else begin
            dfs_s_d = capture_val;
         end
      end
   end

   // read port and refusal of unprivileged access
   always_comb begin
      rdata_d  = 32'h0000_0000;
      rvalid_d = 1'b0;
      undef_d  = 1'b0;
      if ((cp_rd_in || cp_wr_in) && sel_hit && !cp_privileged_in) begin // RULE2
         undef_d = 1'b1;
      end else if (cp_rd_in && sel_hit) begin // RULE20
         rvalid_d = 1'b1;
         rdata_d  = cp_nonsecure_in ? dfs_ns_q : dfs_s_q;
      end
   end

   // banked register state
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dfs_s_q  <= DFS_RESET; // RULE19
         dfs_ns_q <= DFS_RESET; // RULE19
      end else begin
         dfs_s_q  <= dfs_s_d;
         dfs_ns_q <= dfs_ns_d;
      end
   end

   // read port state
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
         undef_q  <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         undef_q  <= undef_d;
      end
   end

   assign cp_rdata_out  = rdata_q;
   assign cp_rvalid_out = rvalid_q;
   assign cp_undef_out  = undef_q;

endmodule

// ==== bench/dfsc_abort_src.sv ====
module dfsc_abort_src (
   input  wire logic        mclk_in,
   output logic             vld_out,
   output logic [14:0]      cause_out,
   output logic [3:0]       dom_out,
   output logic             wr_out,
   output logic             cp_out,
   output logic             slv_out,
   output logic             ns_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {vld_out, cause_out, dom_out, wr_out, cp_out, slv_out, ns_out} = '0;
   end
   // one-cycle abort report; domain and qualifiers except ns_out turn over once released
   task automatic raise(input logic [14:0] c, input logic [3:0] d, input logic w, p, s, n);
      @(posedge mclk_in);
      {vld_out, cause_out, dom_out, wr_out, cp_out, slv_out, ns_out} <= {1'b1, c, d, w, p, s, n};
      @(posedge mclk_in);
      {vld_out, cause_out, dom_out, wr_out, cp_out, slv_out} <= {1'b0, 15'h0, ~d, ~w, ~p, ~s};
   endtask
endmodule

// ==== bench/dfsc_capture_chk.sv ====
module dfsc_capture_chk (
   input wire logic        mclk_in,
   input wire logic        arst_n_in,
   input wire logic        abort_valid_in,
   input wire logic [14:0] abort_cause_in,
   input wire logic [3:0]  abort_domain_in,
   input wire logic        abort_cp_op_in,
   input wire logic        abort_nonsecure_in,
   input wire logic        cp_rd_in,
   input wire logic        cp_wr_in,
   input wire logic [3:0]  cp_crn_in,
   input wire logic [3:0]  cp_crm_in,
   input wire logic [2:0]  cp_opc2_in,
   input wire logic        cp_privileged_in,
   input wire logic        cp_nonsecure_in,
   input wire logic [31:0] cp_rdata_out,
   input wire logic        cp_rvalid_out,
   input wire logic        cp_undef_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   logic hit;
   logic rd_ok;
   assign hit = cp_crn_in == 4'h5 && cp_crm_in == 4'h0 && cp_opc2_in == 3'h0;
   assign rd_ok = cp_rd_in && hit && cp_privileged_in && !cp_wr_in && !abort_valid_in;
   // abort, a quiet cycle, then a read of the same bank
   sequence ab_rd;
      abort_valid_in ##1 !abort_valid_in && !cp_wr_in
      ##1 rd_ok && cp_nonsecure_in == $past(abort_nonsecure_in, 2);
   endsequence
   read_answer_a: assert property (rd_ok |=> cp_rvalid_out && !cp_undef_out)
      else $error("read not answered");
   answer_cause_a: assert property (cp_rvalid_out |-> $past(cp_rd_in && hit))
      else $error("answer without read");
   unpriv_refuse_a: assert property ((cp_rd_in || cp_wr_in) && hit && !cp_privileged_in
      |=> cp_undef_out && !cp_rvalid_out) else $error("unprivileged access served");
   zero_bits_a: assert property (cp_rvalid_out |-> cp_rdata_out[31:13] == 19'h0
      && cp_rdata_out[9:8] == 2'h0) else $error("reserved bits set");
   idle_zero_a: assert property (!cp_rvalid_out |-> cp_rdata_out == 32'h0)
      else $error("read data without valid");
   align_code_a: assert property (abort_cause_in[0] ##0 ab_rd |=> cp_rdata_out[3:0] == 4'h1
      && !cp_rdata_out[10] && !cp_rdata_out[12]) else $error("alignment code wrong");
   cp_write_a: assert property (abort_cp_op_in && |abort_cause_in ##0 ab_rd
      |=> cp_rdata_out[11]) else $error("coprocessor abort not write");
   domain_cap_a: assert property (|abort_cause_in ##0 ab_rd
      |=> cp_rdata_out[7:4] == $past(abort_domain_in, 3)) else $error("domain wrong");
endmodule
bind dfsc_capture dfsc_capture_chk chk (.*);

// ==== bench/data_fault_status_capture_bench.sv ====
module data_fault_status_capture_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in, arst_n_in, cp_rd_in, cp_wr_in, cp_privileged_in, cp_nonsecure_in;
   logic        abort_valid_in, abort_write_in, abort_cp_op_in, abort_slverr_in;
   logic        abort_nonsecure_in, cp_rvalid_out, cp_undef_out;
   logic [14:0] abort_cause_in;
   logic [3:0]  abort_domain_in;
   logic [3:0]  cp_crn_in = 4'h5;
   logic [3:0]  cp_crm_in = 4'h0;
   logic [2:0]  cp_opc2_in;
   logic [31:0] cp_wdata_in, cp_rdata_out, exp;
   logic [4:0]  fs_tab [15] = '{5'h01, 5'h04, 5'h0C, 5'h0E, 5'h05, 5'h07, 5'h03, 5'h06,
                               5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h08, 5'h16, 5'h02};
   int          num_errors, cmp_count;
   dfsc_abort_src src (.mclk_in(mclk_in), .vld_out(abort_valid_in), .cause_out(abort_cause_in),
      .dom_out(abort_domain_in), .wr_out(abort_write_in), .cp_out(abort_cp_op_in),
      .slv_out(abort_slverr_in), .ns_out(abort_nonsecure_in));
   dfsc_capture dut (.*);
   task automatic chk(input logic [31:0] got, e);
      cmp_count++;
      if (got !== e) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic acc(input logic r, w, p, n, input logic [2:0] o, input logic [31:0] d);
      @(posedge mclk_in);
      {cp_rd_in, cp_wr_in, cp_privileged_in, cp_nonsecure_in} <= {r, w, p, n};
      cp_opc2_in <= o;
      cp_wdata_in <= d;
      @(posedge mclk_in);
      {cp_rd_in, cp_wr_in} <= 2'b00;
      cp_wdata_in <= ~d;
      #1;
   endtask
   task automatic rd(input logic n, input logic [31:0] e);
      acc(1'b1, 1'b0, 1'b1, n, 3'h0, 32'h0);
      chk({31'h0, cp_rvalid_out}, 32'h1);
      chk(cp_rdata_out, e);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (5000) @(posedge mclk_in);
      num_errors++;
      $display("ERROR %0t: run hung", $time);
      tally_and_finish();
   end
   initial begin
      {arst_n_in, cp_rd_in, cp_wr_in, cp_privileged_in, cp_nonsecure_in} = '0;
      cp_opc2_in = 3'h0;
      cp_wdata_in = 32'h0;
      repeat (10) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      rd(1'b0, 32'h0);
      rd(1'b1, 32'h0);
      $display("test reset_values done");
      // every cause wins over all lower ones raised with it
      for (int i = 0; i < 15; i++) begin
         src.raise(15'h7FFF << i, i[3:0], i[0], i == 4, i[1], 1'b0);
         exp = {19'h0, i[1] & (i inside {2, 3, 12, 13}), i[0] | (i == 4), fs_tab[i][4], 2'b0,
                i[3:0], fs_tab[i][3:0]};
         rd(1'b0, exp);
      end
      $display("test abort_codes done");
      rd(1'b0, exp);
      rd(1'b1, 32'h0);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, ~exp);
      rd(1'b0, ~exp & 32'h0000_1CFF);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 32'h0);
      chk({31'h0, cp_undef_out}, 32'h1);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 32'h0);
      chk({31'h0, cp_rvalid_out}, 32'h0);
      src.raise(15'h0001, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(1'b1, 32'h0000_00F1);
      rd(1'b0, ~exp & 32'h0000_1CFF);
      // abort and write hit the same bank in one cycle: the abort is kept
      fork
         src.raise(15'h4000, 4'h3, 1'b0, 1'b0, 1'b0, 1'b1);
         acc(1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 32'h0000_1CFF);
      join
      rd(1'b1, 32'h0000_0032);
      $display("test access_rules done");
      tally_and_finish();
   end
endmodule
